// ### core/dpri_params.svh
`ifndef DPRI_PARAMS_SVH
`define DPRI_PARAMS_SVH
// register offsets of the controller (byte addresses, word aligned)
`define DPRI_OFS_CTRL       4'h0
`define DPRI_OFS_CODE       4'h4
`define DPRI_OFS_RANGE      4'h8
`define DPRI_OFS_STATUS     4'hC
// command field of the control register
`define DPRI_CMD_LSB        0
`define DPRI_CMD_W          3
// busy bit of the status register
`define DPRI_STAT_BUSY      0
// range code used after reset
`define DPRI_RANGE_RESET    3'h0
// reserved range codes start here
`define DPRI_RANGE_FIRST_RSV 3'h6
// timing figures and the clock period in ns
`define DPRI_CLK_NS         50
`define DPRI_STROBE_NS      30
`define DPRI_BUS_ACTIVE_NS  40
`define DPRI_CLR_NS         30
`define DPRI_STROBE_CYC     ((`DPRI_STROBE_NS + `DPRI_CLK_NS - 1) / `DPRI_CLK_NS)
`define DPRI_BUS_CYC        ((`DPRI_BUS_ACTIVE_NS + `DPRI_CLK_NS - 1) / `DPRI_CLK_NS + 1)
`define DPRI_CLR_CYC        ((`DPRI_CLR_NS + `DPRI_CLK_NS - 1) / `DPRI_CLK_NS)
`endif

// ### core/dpri_pkg.sv
package dpri_pkg;
    // commands written into the control register
    typedef enum logic [2:0] {
        DPRI_CMD_NONE       = 3'h0,
        DPRI_CMD_WRITE_CODE = 3'h1,
        DPRI_CMD_WRITE_RNG  = 3'h2,
        DPRI_CMD_UPDATE     = 3'h3,
        DPRI_CMD_READ_IN    = 3'h4,
        DPRI_CMD_READ_DAC   = 3'h5,
        DPRI_CMD_CLEAR      = 3'h6
    } dpri_cmd_t;
    // pin sequencer states, one-hot
    typedef enum logic [5:0] {
        DPRI_ST_IDLE  = 6'b000001,
        DPRI_ST_SETUP = 6'b000010,
        DPRI_ST_PULSE = 6'b000100,
        DPRI_ST_RDUPD = 6'b001000,
        DPRI_ST_WAIT  = 6'b010000,
        DPRI_ST_END   = 6'b100000
    } dpri_state_t;
endpackage

// ### core/dpri_sync.sv
// two-stage synchroniser, one per bit
module dpri_sync #(
    parameter int WIDTH = 16
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_ce,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    // state: both stages
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } dpri_sync_t;
    dpri_sync_t q;
    dpri_sync_t next_q;

    ////////////////////////////////////////////////////////////////////////
    // next state: first stage read only by second
    always_comb
    begin
        next_q      = q;
        if (i_ce)
        begin
            next_q.meta = i_async;
            next_q.sync = q.meta;
        end
    end

    // registers
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            q <= '0;
        else
            q <= next_q;
    end

    assign o_sync = q.sync;
endmodule

// ### core/dpri_host.sv
// What this block does
// RULE_01: device keeps four registers, two per port
// RULE_02: code write: select low, write strobe low
// RULE_03: update pulse high with read low copies
// RULE_04: range write: select high, write strobe low
// RULE_05: range three bits, code twelve to sixteen
// RULE_06: every update moves both ports together
// RULE_07: write low plus update high is transparent
// RULE_08: deglitch starts at update rising edge
// RULE_09: tied strobes act as master-slave clock
// RULE_10: range shares low code lines, never both
// RULE_11: clear low zeroes code, keeps range
// RULE_12: clear code depends on present range
// RULE_13: power-on gives zero code, first range
// RULE_14: range codes six used, rest reserved
// RULE_15: fixed range: strap high, select low; host still drives select high for range-port reads
// RULE_16: fixed range registers ignore write, update
// RULE_17: fixed range gives no range readback
// RULE_18: bus driven only on read, selected port
// RULE_19: read high disables writes; update selects
// RULE_20: raise read before update for dac read
// RULE_21: drop update before read ends readback
`include "dpri_params.svh"
module dpri_host #(
    parameter int CODE_W = 16
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_ce,
    // avalon-mm slave
    input  wire logic [3:0]        i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    output logic      [31:0]       o_avs_readdata,
    output logic                   o_avs_waitrequest,
    // fixed range strap seen at the device
    input  wire logic              i_fixed_range_strap,
    // device pins
    input  wire logic [CODE_W-1:0] i_code_bits,
    output logic      [CODE_W-1:0] o_code_bits,
    output logic      [CODE_W-1:0] o_code_bits_oe,
    input  wire logic [2:0]        i_range_bits,
    output logic      [2:0]        o_range_bits,
    output logic      [2:0]        o_range_bits_oe,
    output logic                   o_port_sel,
    output logic                   o_write_n,
    output logic                   o_update_strobe,
    output logic                   o_read,
    output logic                   o_clear_n
);
    // elaboration check on code width
    if (CODE_W != 12 && CODE_W != 14 && CODE_W != 16)
    begin : g_bad_width
        $error("code width must be 12, 14 or 16");
    end

    localparam logic [3:0] STROBE_CYC = 4'(`DPRI_STROBE_CYC);
    localparam logic [3:0] BUS_CYC    = 4'(`DPRI_BUS_CYC);
    localparam logic [3:0] CLR_CYC    = 4'(`DPRI_CLR_CYC);

    // all state of the controller
    typedef struct packed {
        dpri_pkg::dpri_state_t st;      // sequencer state
        dpri_pkg::dpri_cmd_t   cmd;     // command in flight
        logic [3:0]            cnt;     // phase counter
        logic [CODE_W-1:0]     code;    // code to write
        logic [2:0]            range;   // range to write
        logic [CODE_W-1:0]     rd_code; // last code read back
        logic [2:0]            rd_range;// last range read back
        logic                  rd_port; // port of last read
        logic                  error;   // refused command seen
        logic                  port_sel;
        logic                  write_n;
        logic                  update_strobe;
        logic                  read;
        logic                  clear_n;
        logic [CODE_W-1:0]     dout;
        logic                  code_oe;
        logic                  range_oe;
        logic [31:0]           rdata;
        logic                  ack;
    } dpri_host_t;
    dpri_host_t q;
    dpri_host_t next_q;

    // synchronised bus readback and fixed range strap
    logic [CODE_W-1:0] code_in_s;
    logic [2:0]        range_in_s;
    logic              strap_s;

    ////////////////////////////////////////////////////////////////////////
    // input synchroniser: pins pass two flip-flops
    dpri_sync #(
        .WIDTH (CODE_W + 4)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_ce       (i_ce),
        .i_async    ({i_fixed_range_strap, i_range_bits, i_code_bits}),
        .o_sync     ({strap_s, range_in_s, code_in_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode helpers
    logic wr_hit;
    logic rd_req;
    logic busy;
    assign busy   = (q.st != dpri_pkg::DPRI_ST_IDLE);
    assign wr_hit = i_avs_write && !i_avs_read;
    assign rd_req = i_avs_read && !i_avs_write;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic: bus slave and pin sequencer
    always_comb
    begin
        next_q     = q;
        if (i_ce)
        begin
            // acknowledge lasts one enabled cycle
            next_q.ack = 1'b0;
            // register access: answered one cycle after request
            if ((wr_hit || rd_req) && !q.ack)
            begin
                next_q.ack   = 1'b1;
                next_q.rdata = 32'h0;
                case (i_avs_address)
                    `DPRI_OFS_CTRL:
                    begin
                        next_q.rdata = {29'h0, q.cmd};
                    end
                    `DPRI_OFS_CODE:
                    begin
                        next_q.rdata = 32'(q.rd_code);
                    end
                    `DPRI_OFS_RANGE:
                    begin
                        next_q.rdata = {29'h0, q.rd_range};
                    end
                    `DPRI_OFS_STATUS:
                    begin
                        next_q.rdata = {28'h0, q.error, strap_s, q.rd_port, busy};
                    end
                    default:
                    begin
                        next_q.rdata = 32'h0;
                    end
                endcase
                if (wr_hit && i_avs_address == `DPRI_OFS_CODE)
                    next_q.code = i_avs_writedata[CODE_W-1:0];
                // RULE_14 reserved codes
                if (wr_hit && i_avs_address == `DPRI_OFS_RANGE)
                begin
                    if (i_avs_writedata[2:0] >= `DPRI_RANGE_FIRST_RSV)
                        next_q.error = 1'b1;
                    else
                        next_q.range = i_avs_writedata[2:0];
                end
                if (wr_hit && i_avs_address == `DPRI_OFS_STATUS && i_avs_writedata[3])
                    next_q.error = 1'b0;
                // commands start only when idle
                if (wr_hit && i_avs_address == `DPRI_OFS_CTRL)
                begin
                    if (busy)
                        next_q.error = 1'b1;
                    // RULE_15 fixed range no range write
                    else if (strap_s && i_avs_writedata[2:0] == 3'(dpri_pkg::DPRI_CMD_WRITE_RNG))
                        next_q.error = 1'b1;
                    else if (i_avs_writedata[2:0] != 3'h0 && i_avs_writedata[2:0] != 3'h7)
                    begin
                        next_q.cmd = dpri_pkg::dpri_cmd_t'(i_avs_writedata[2:0]);
                        next_q.st  = dpri_pkg::DPRI_ST_SETUP;
                        next_q.cnt = 4'h0;
                    end
                end
            end

            // pin sequencer
            case (q.st)
                dpri_pkg::DPRI_ST_IDLE:
                begin
                    next_q.write_n  = 1'b1;
                    next_q.update_strobe      = 1'b0;
                    next_q.read     = 1'b0;
                    next_q.clear_n  = 1'b1;
                    next_q.code_oe  = 1'b0;
                    next_q.range_oe = 1'b0;
                end
                dpri_pkg::DPRI_ST_SETUP:
                begin
                    next_q.cnt = 4'h0;
                    next_q.st  = dpri_pkg::DPRI_ST_PULSE;
                    case (q.cmd)
                        // RULE_02 code port select low
                        dpri_pkg::DPRI_CMD_WRITE_CODE:
                        begin
                            next_q.port_sel = 1'b0;
                            next_q.dout     = q.code;
                            next_q.code_oe  = 1'b1;
                        end
                        // RULE_04 range port select high
                        // RULE_10 only low lines driven
                        dpri_pkg::DPRI_CMD_WRITE_RNG:
                        begin
                            next_q.port_sel = 1'b1;
                            next_q.dout     = {{(CODE_W-3){1'b0}}, q.range};
                            next_q.range_oe = 1'b1;
                        end
                        // RULE_18 bus released before read
                        // RULE_20 read raised first
                        dpri_pkg::DPRI_CMD_READ_IN,
                        dpri_pkg::DPRI_CMD_READ_DAC:
                        begin
                            next_q.port_sel = q.rd_port;
                            next_q.read     = 1'b1;
                        end
                        default:
                        begin
                            next_q.port_sel = 1'b0;
                        end
                    endcase
                end
                dpri_pkg::DPRI_ST_PULSE:
                begin
                    next_q.cnt = q.cnt + 4'h1;
                    case (q.cmd)
                        // RULE_02 write strobe low pulse
                        dpri_pkg::DPRI_CMD_WRITE_CODE,
                        dpri_pkg::DPRI_CMD_WRITE_RNG:
                            next_q.write_n = 1'b0;
                        // RULE_03 update pulse, read low
                        // RULE_06 both ports updated
                        dpri_pkg::DPRI_CMD_UPDATE:
                            next_q.update_strobe = 1'b1;
                        // RULE_11 clear pulse low
                        dpri_pkg::DPRI_CMD_CLEAR:
                            next_q.clear_n = 1'b0;
                        // RULE_19 update selects dac register
                        dpri_pkg::DPRI_CMD_READ_DAC:
                            next_q.update_strobe = 1'b1;
                        default:
                            next_q.update_strobe = 1'b0;
                    endcase
                    if (q.cnt + 4'h1 >= ((q.cmd == dpri_pkg::DPRI_CMD_READ_IN ||
                                         q.cmd == dpri_pkg::DPRI_CMD_READ_DAC) ? BUS_CYC + 4'h2 :
                                        (q.cmd == dpri_pkg::DPRI_CMD_CLEAR) ? CLR_CYC : STROBE_CYC))
                        next_q.st = dpri_pkg::DPRI_ST_WAIT;
                end
                dpri_pkg::DPRI_ST_WAIT:
                begin
                    // capture readback from synchronised pins
                    if (q.cmd == dpri_pkg::DPRI_CMD_READ_IN || q.cmd == dpri_pkg::DPRI_CMD_READ_DAC)
                    begin
                        if (q.port_sel)
                            next_q.rd_range = range_in_s;
                        else
                            next_q.rd_code  = code_in_s;
                    end
                    // RULE_21 update dropped before read
                    next_q.update_strobe     = 1'b0;
                    next_q.write_n = 1'b1;
                    next_q.clear_n = 1'b1;
                    next_q.st      = dpri_pkg::DPRI_ST_END;
                end
                dpri_pkg::DPRI_ST_END:
                begin
                    // hold data past strobe rise, then release
                    next_q.read     = 1'b0;
                    next_q.code_oe  = 1'b0;
                    next_q.range_oe = 1'b0;
                    next_q.st       = dpri_pkg::DPRI_ST_IDLE;
                end
                default:
                begin
                    next_q.st = dpri_pkg::DPRI_ST_IDLE;
                end
            endcase
            // read port picked by range-port flag in data bit 3 of command
            if (wr_hit && i_avs_address == `DPRI_OFS_CTRL && !busy && !q.ack)
                next_q.rd_port = i_avs_writedata[3];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            q          <= '0;
            q.st       <= dpri_pkg::DPRI_ST_IDLE;
            q.cmd      <= dpri_pkg::DPRI_CMD_NONE;
            q.write_n  <= 1'b1;
            q.clear_n  <= 1'b1;
            q.range    <= `DPRI_RANGE_RESET;
        end
        else
        begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_avs_readdata    = q.rdata;
    // frozen slave keeps the master waiting
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !(q.ack && i_ce);
    assign o_code_bits       = q.dout;
    assign o_code_bits_oe    = {CODE_W{q.code_oe}};
    assign o_range_bits      = q.dout[2:0];
    assign o_range_bits_oe   = {3{q.range_oe}};
    assign o_port_sel        = q.port_sel;
    assign o_write_n         = q.write_n;
    assign o_update_strobe   = q.update_strobe;
    assign o_read            = q.read;
    assign o_clear_n         = q.clear_n;
endmodule

// ### tb/dpri_checker.sv
module dpri_checker #(
    parameter int CODE_W = 16
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_sys_rst,
    input  wire logic [CODE_W-1:0] o_code_bits_oe,
    input  wire logic [2:0]        o_range_bits_oe,
    input  wire logic              o_port_sel,
    input  wire logic              o_write_n,
    input  wire logic              o_update_strobe,
    input  wire logic              o_read
);
    timeunit 1ns;
    timeprecision 1ns;
    // one clock domain for all checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);
    ////////////////////////////////////////////////////////////
    property p_rd_hiz;
        o_read |-> (o_code_bits_oe == '0) && (o_range_bits_oe == '0);
    endproperty
    a_rd_hiz: assert property (p_rd_hiz) else $error("bus driven in readback");
    property p_wr_no_rd;
        !o_write_n |-> !o_read;
    endproperty
    a_wr_no_rd: assert property (p_wr_no_rd) else $error("write during read");
    property p_code_sel;
        (|o_code_bits_oe) |-> !o_port_sel;
    endproperty
    a_code_sel: assert property (p_code_sel) else $error("code driven, range port");
    property p_rng_sel;
        (|o_range_bits_oe) |-> o_port_sel;
    endproperty
    a_rng_sel: assert property (p_rng_sel) else $error("range driven, code port");
    property p_wr_data;
        !o_write_n |-> (o_port_sel ? (&o_range_bits_oe) : (&o_code_bits_oe));
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("strobe without data");
    property p_wr_pulse;
        $fell(o_write_n) |=> o_write_n && !o_read;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse length");
    property p_rd_first;
        $rose(o_update_strobe) && o_read |-> $past(o_read);
    endproperty
    a_rd_first: assert property (p_rd_first) else $error("update before read");
    property p_rd_end;
        $fell(o_read) |-> !$past(o_update_strobe);
    endproperty
    a_rd_end: assert property (p_rd_end) else $error("read ended with update");
    ////////////////////////////////////////////////////////////
    // main scenarios reached
    c_write: cover property (!o_write_n && !o_port_sel);
    c_rd_dac: cover property (o_read && o_update_strobe);
    c_rd_end: cover property ($fell(o_read));
endmodule

bind dpri_host dpri_checker #(.CODE_W(CODE_W)) dpri_checker_inst (
    .i_core_clk      (i_core_clk),
    .i_sys_rst       (i_sys_rst),
    .o_code_bits_oe  (o_code_bits_oe),
    .o_range_bits_oe (o_range_bits_oe),
    .o_port_sel      (o_port_sel),
    .o_write_n       (o_write_n),
    .o_update_strobe (o_update_strobe),
    .o_read          (o_read)
);

// ### tb/dpri_dev_model.sv
module dpri_dev_model #(
    parameter int CODE_W = 16
) (
    input  wire logic [CODE_W-1:0] i_code_bus,
    input  wire logic [2:0]        i_range_bus,
    input  wire logic              i_port_sel,
    input  wire logic              i_write_n,
    input  wire logic              i_update_strobe,
    input  wire logic              i_read,
    input  wire logic              i_clear_n,
    input  wire logic              i_fixed_range_strap,
    input  wire logic [2:0]        i_fixed_range,
    output logic      [CODE_W-1:0] o_code_bits,
    output logic                   o_code_oe,
    output logic      [2:0]        o_range_bits,
    output logic                   o_range_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [CODE_W-1:0] code_in = '0;
    logic [CODE_W-1:0] code_dac = '0;
    logic [2:0]        rng_in = 3'h0;
    logic [2:0]        rng_dac = 3'h0;
    wire  [2:0]        rng_in_eff = i_fixed_range_strap ? i_fixed_range : rng_in;
    wire  [2:0]        rng_dac_eff = i_fixed_range_strap ? i_fixed_range : rng_dac;
    function automatic logic [CODE_W-1:0] zero_code(input logic [2:0] r);
        zero_code = '0;
        if (r == 3'h5)
            zero_code[CODE_W-2] = 1'b1;
        else if (r >= 3'h2 && r <= 3'h4)
            zero_code[CODE_W-1] = 1'b1;
    endfunction
    ////////////////////////////////////////////////////////////
    // strobes act as edges, no clock
    // write, read and clear falling edges, update rising edge
    always @(negedge i_write_n or posedge i_update_strobe or negedge i_read or negedge i_clear_n)
    begin
        if (!i_clear_n)
        begin
            code_in = zero_code(rng_dac_eff);
            code_dac = zero_code(rng_dac_eff);
        end
        else if (!i_read)
        begin
            if (!i_write_n && !i_port_sel)
                code_in = i_code_bus;
            else if (!i_write_n && !i_fixed_range_strap)
                rng_in = i_range_bus;
            if (i_update_strobe)
            begin
                code_dac = code_in;
                rng_dac = rng_in;
            end
        end
    end
    assign o_code_oe = i_read && !i_port_sel;
    assign o_range_oe = i_read && i_port_sel && !i_fixed_range_strap;
    assign o_code_bits = i_update_strobe ? code_dac : code_in;
    assign o_range_bits = i_update_strobe ? rng_dac_eff : rng_in_eff;
endmodule

// ### tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_core_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        i_ce = 1'b1;
    logic [3:0]  i_avs_address = 4'h0;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [31:0] rdata, last_q;
    logic        waitreq, strap = 1'b0;
    logic [2:0]  fix = 3'h0;
    logic [15:0] c_out, c_oe, d_out, code_bus, dac = 16'h0, v, z, pat = 16'hA5A5;
    logic [2:0]  r_out, r_oe, m_r_out, rng_bus;
    logic        m_c_oe, m_r_oe, sel, wr_n, update_strobe, rd_pin, clr_n;
    logic [32:0] exp_q[$];
    logic [32:0] note;
    int          n_fail = 0;
    int          check_count = 0;
    always #25 i_core_clk = ~i_core_clk;
    // released lines show a changing pattern
    always @(posedge i_core_clk) pat <= ~pat;
    assign code_bus = (c_oe & c_out) | (~c_oe & (m_c_oe ? d_out : pat));
    assign rng_bus = strap ? fix : ((r_oe & r_out) | (~r_oe & (m_r_oe ? m_r_out : pat[2:0])));
    dpri_host #(.CODE_W(16)) dpri_host_inst (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_fixed_range_strap(strap), .i_code_bits(code_bus), .o_code_bits(c_out),
        .o_code_bits_oe(c_oe), .i_range_bits(rng_bus), .o_range_bits(r_out),
        .o_range_bits_oe(r_oe), .o_port_sel(sel), .o_write_n(wr_n),
        .o_update_strobe(update_strobe), .o_read(rd_pin), .o_clear_n(clr_n));
    dpri_dev_model #(.CODE_W(16)) dpri_dev_model_inst (
        .i_code_bus(code_bus), .i_range_bus(rng_bus), .i_port_sel(sel), .i_write_n(wr_n),
        .i_update_strobe(update_strobe), .i_read(rd_pin), .i_clear_n(clr_n),
        .i_fixed_range_strap(strap), .i_fixed_range(fix), .o_code_bits(d_out),
        .o_code_oe(m_c_oe), .o_range_bits(m_r_out), .o_range_oe(m_r_oe));
    ////////////////////////////////////////////////////////////
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one avalon access, held until waitrequest low
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_read <= !wr;
        i_avs_write <= wr;
        do
        begin
            @(posedge i_core_clk);
            n++;
        end
        while (waitreq !== 1'b0 && n < 100);
        // answer taken at the edge where waitrequest is low
        last_q = rdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        if (n >= 100)
        begin
            n_fail++;
            test_done();
        end
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back({1'b1, e});
        bus(1'b0, a, 32'h0);
    endtask
    // command, then poll busy
    task cmd(input logic [31:0] c);
        int n;
        n = 0;
        bus(1'b1, 4'h0, c);
        do
        begin
            exp_q.push_back(33'h0);
            bus(1'b0, 4'hC, 32'h0);
            n++;
        end
        while (last_q[0] !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            n_fail++;
            test_done();
        end
    endtask
    task rbk(input logic [31:0] c, input logic [3:0] a, input logic [31:0] e);
        cmd(c);
        rd(a, e);
    endtask
    // result watcher takes oldest note
    always @(negedge i_core_clk)
        if (i_avs_read && waitreq === 1'b0 && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            if (note[32])
                chk("readdata", rdata, note[31:0]);
        end
    ////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(20676));
        repeat (5) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        rd(4'hC, 32'h0);
        rd(4'h8, 32'h0);
        rd(4'h2, 32'h0);
        rbk(32'h5, 4'h4, 32'h0);
        rbk(32'hD, 4'h8, 32'h0);
        // every used range code in turn
        for (int r = 0; r < 6; r++)
        begin
            v = 16'($urandom);
            z = (r == 5) ? 16'h4000 : ((r >= 2 && r <= 4) ? 16'h8000 : 16'h0);
            bus(1'b1, 4'h8, 32'(r));
            cmd(32'h2);
            rbk(32'hC, 4'h8, 32'(r));
            cmd(32'h3);
            rbk(32'h5, 4'h4, {16'h0, dac});
            rbk(32'hD, 4'h8, 32'(r));
            bus(1'b1, 4'h4, {16'h0, v});
            cmd(32'h1);
            rbk(32'h4, 4'h4, {16'h0, v});
            rbk(32'h5, 4'h4, {16'h0, dac});
            cmd(32'h3);
            rbk(32'h5, 4'h4, {16'h0, v});
            cmd(32'h6);
            rbk(32'h4, 4'h4, {16'h0, z});
            rbk(32'h5, 4'h4, {16'h0, z});
            rbk(32'hD, 4'h8, 32'(r));
            dac = z;
        end
        // reserved range refused, error cleared
        cmd(32'h4);
        bus(1'b1, 4'h8, 32'h6);
        rd(4'hC, 32'h8);
        bus(1'b1, 4'hC, 32'h8);
        rd(4'hC, 32'h0);
        // fixed range strap
        strap <= 1'b1;
        fix <= 3'h5;
        // let the strap pass the two-stage synchroniser
        repeat (2) @(posedge i_core_clk);
        cmd(32'h2);
        rd(4'hC, 32'hC);
        bus(1'b1, 4'h4, 32'h1234);
        cmd(32'h1);
        cmd(32'h3);
        cmd(32'h6);
        rbk(32'h5, 4'h4, 32'h4000);
        // freeze in mid readback, state must hold
        bus(1'b1, 4'h0, 32'h5);
        i_ce <= 1'b0;
        repeat (20) @(posedge i_core_clk);
        chk("read_pin", {31'h0, rd_pin}, 32'h1);
        i_ce <= 1'b1;
        repeat (20) @(posedge i_core_clk);
        rd(4'hC, 32'hC);
        rd(4'h4, 32'h4000);
        test_done();
    end
endmodule
